/* File: inc/phy_an_energy_detect_powerdown_pkg.sv */
// Constants, types and state layout of the partner, expansion and power-down timing registers
//
// Notes on behaviour
// - Partner next-page bit 15 resets to 0; local next-page exchange unsupported.
// - Partner bit 14 reads 1 once a link code word arrived since the last restart, else 0.
// - Partner bit 13 mirrors the remote fault flag the partner sent.
// - Partner bits 11:10 report partner pause ability; reset value 00.
// - Partner bit 9 reports advertised 100BASE-T4 ability though local PHY lacks it.
// - Partner bits 8..5 report TX full, TX, 10 full, 10 abilities; reset 0.
// - Expansion bit 4 sets on a parallel detection fault and latches high.
// - Expansion bit 3 shows whether the partner advertises next-page ability.
// - Expansion bit 2, local next-page ability, always reads 0.
// - Expansion bit 1 sets when a new page arrives and latches high.
// - Expansion bit 0 shows whether the partner can auto-negotiate.
// - In power-down with timing bit 15 set, single link pulses are sent periodically.
// - Timing bits 14:13 pick pulse interval: 1 s, 768, 512, 256 ms.
// - In power-down with timing bit 12 set, one received pulse wakes the PHY.
// - Else bits 11:10 give max two-pulse spacing: 64, 256, 512 ms, 1 s.
// - With the power-down enable bit set, timing bit 1 lengthens crossover time by 2976 ms.
// - Crossover enabled and forced speed: timing bit 0 adds 1984 ms to crossover time.
// - Pulse timing settings act only while the power-down enable bit is set.
package phy_an_energy_detect_powerdown_pkg;

   // ************************************************************
   // Register map: printed indices, byte address is four times the index
   // ************************************************************
   localparam logic [5:0]  IDX_PARTNER   = 6'h05;
   localparam logic [5:0]  IDX_EXPANSION = 6'h06;
   localparam logic [5:0]  IDX_TIMING    = 6'h10;
   localparam logic [5:0]  IDX_MODECTL   = 6'h11;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int P_NEXTPAGE = 15;
   localparam int P_ACK      = 14;
   localparam int P_RFAULT   = 13;
   localparam int P_RSVD     = 12;
   localparam int X_PDFAULT  = 4;
   localparam int X_PARTNP   = 3;
   localparam int X_LOCALNP  = 2;
   localparam int X_PAGERX   = 1;
   localparam int X_PARTAN   = 0;
   localparam int T_TXEN     = 15;
   localparam int T_TXSEL    = 13;
   localparam int T_RXSINGLE = 12;
   localparam int T_RXSEL    = 10;
   localparam int T_EXTEDPD  = 1;
   localparam int T_EXTMAN   = 0;
   localparam int M_EDPDEN   = 13;
   localparam logic [15:0] TIMING_MASK  = 16'hFC03;
   localparam logic [15:0] PARTNER_MASK = 16'hAFFF;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [15:0] PARTNER_RST = 16'h0000;
   localparam logic [15:0] TIMING_RST  = 16'h0000;

   // ************************************************************
   // Clock rate in kHz and times in milliseconds
   // ************************************************************
   localparam int CLK_KHZ          = 125000;
   localparam int MS_TX_1S         = 1000;
   localparam int MS_TX_768        = 768;
   localparam int MS_TX_512        = 512;
   localparam int MS_TX_256        = 256;
   localparam int MS_RX_64         = 64;
   localparam int MS_RX_256        = 256;
   localparam int MS_RX_512        = 512;
   localparam int MS_RX_1S         = 1000;
   localparam logic [12:0] MS_EXT_ENERGY_DETECT_POWERDOWN   = 13'hBA0;
   localparam logic [12:0] MS_EXT_MANUAL = 13'h7C0;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      ST_AWAKE = 2'b00,
      ST_ENERGY_DETECT_POWERDOWN  = 2'b01,
      ST_WAKE  = 2'b11
   } pd_state_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] word;
   } code_word_t;

   typedef struct packed {
      pd_state_t   st;
      logic [15:0] partner;
      logic        ack;
      logic        anAble;
      logic        pdFault;
      logic        pageRx;
      logic [15:0] timing;
      logic        edpdEn;
      logic [31:0] msCnt;
      logic        msTick;
      logic [11:0] txMs;
      logic [11:0] rxMs;
      logic        rxFirst;
      logic        txPulse;
      logic        wake;
      logic [12:0] xoverExt;
      logic [31:0] rdata;
      logic        slverr;
   } phy_state_t;

endpackage

/* File: src/phy_an_energy_detect_powerdown_regs.sv */
// Partner ability, expansion and power-down timing registers with APB slave
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module phy_an_energy_detect_powerdown_regs #(
   parameter int MS_CYCLES = phy_an_energy_detect_powerdown_pkg::CLK_KHZ
) (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire phy_an_energy_detect_powerdown_pkg::code_word_t codeWord,
   input  wire logic                        anRestart,
   input  wire logic                        pdFaultEvt,
   input  wire logic                        rxLinkPulse,
   input  wire logic                        energyPresent,
   input  wire logic                        crossoverEnable,
   input  wire logic                        forcedManual,
   output logic                             txLinkPulse,
   output logic                             edpdActive,
   output logic                             wakeEvt,
   output logic      [12:0]                 xoverExtendMs
);

   // ************************************************************
   // Bus decode
   // ************************************************************
   phy_an_energy_detect_powerdown_pkg::phy_state_t s_r;
   phy_an_energy_detect_powerdown_pkg::phy_state_t s_nxt;
   logic                        setupPh;
   logic                        accessPh;
   logic [5:0]                  regIdx;
   logic                        hitAny;
   logic [15:0]                 rdWord;
   logic [15:0]                 partnerView;
   logic [15:0]                 expView;
   logic                        rdExpDone;
   logic [11:0]                 txLimit;
   logic [11:0]                 rxLimit;

   assign setupPh  = psel && !penable;
   assign accessPh = psel && penable;
   assign regIdx   = paddr[7:2];
   assign hitAny   = (paddr[1:0] == 2'h0) &&
                     (regIdx == phy_an_energy_detect_powerdown_pkg::IDX_PARTNER || regIdx == phy_an_energy_detect_powerdown_pkg::IDX_EXPANSION ||
                      regIdx == phy_an_energy_detect_powerdown_pkg::IDX_TIMING  || regIdx == phy_an_energy_detect_powerdown_pkg::IDX_MODECTL);
   // Read latency is fixed: data is captured in setup, so access always ends in one cycle
   assign pready   = accessPh;
   assign prdata   = s_r.rdata;
   assign pslverr  = accessPh && s_r.slverr;
   assign rdExpDone = accessPh && !pwrite && hitAny && regIdx == phy_an_energy_detect_powerdown_pkg::IDX_EXPANSION;

   always_comb begin
      partnerView = s_r.partner & phy_an_energy_detect_powerdown_pkg::PARTNER_MASK;
      partnerView[phy_an_energy_detect_powerdown_pkg::P_ACK] = s_r.ack;
      expView = 16'h0000;
      expView[phy_an_energy_detect_powerdown_pkg::X_PDFAULT] = s_r.pdFault;
      expView[phy_an_energy_detect_powerdown_pkg::X_PARTNP]  = s_r.partner[phy_an_energy_detect_powerdown_pkg::P_NEXTPAGE];
      expView[phy_an_energy_detect_powerdown_pkg::X_LOCALNP] = 1'b0;
      expView[phy_an_energy_detect_powerdown_pkg::X_PAGERX]  = s_r.pageRx;
      expView[phy_an_energy_detect_powerdown_pkg::X_PARTAN]  = s_r.anAble;
      rdWord = 16'h0000;
      unique case (regIdx)
         phy_an_energy_detect_powerdown_pkg::IDX_PARTNER:   rdWord = partnerView;
         phy_an_energy_detect_powerdown_pkg::IDX_EXPANSION: rdWord = expView;
         phy_an_energy_detect_powerdown_pkg::IDX_TIMING:    rdWord = s_r.timing;
         phy_an_energy_detect_powerdown_pkg::IDX_MODECTL:   rdWord = {2'h0, s_r.edpdEn, 13'h0000};
         default:                        rdWord = 16'h0000;
      endcase
   end

   // ************************************************************
   // Interval selection
   // ************************************************************
   always_comb begin
      unique case (s_r.timing[phy_an_energy_detect_powerdown_pkg::T_TXSEL +: 2])
         2'h0:    txLimit = 12'(phy_an_energy_detect_powerdown_pkg::MS_TX_1S);
         2'h1:    txLimit = 12'(phy_an_energy_detect_powerdown_pkg::MS_TX_768);
         2'h2:    txLimit = 12'(phy_an_energy_detect_powerdown_pkg::MS_TX_512);
         default: txLimit = 12'(phy_an_energy_detect_powerdown_pkg::MS_TX_256);
      endcase
      unique case (s_r.timing[phy_an_energy_detect_powerdown_pkg::T_RXSEL +: 2])
         2'h0:    rxLimit = 12'(phy_an_energy_detect_powerdown_pkg::MS_RX_64);
         2'h1:    rxLimit = 12'(phy_an_energy_detect_powerdown_pkg::MS_RX_256);
         2'h2:    rxLimit = 12'(phy_an_energy_detect_powerdown_pkg::MS_RX_512);
         default: rxLimit = 12'(phy_an_energy_detect_powerdown_pkg::MS_RX_1S);
      endcase
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.txPulse = 1'b0;
      s_nxt.wake    = 1'b0;

      // Bus side: capture read data in setup
      if (setupPh) begin
         // Refused addresses read zero, even when the index alone would match
         s_nxt.rdata  = hitAny ? {16'h0000, rdWord} : 32'h0000_0000;
         s_nxt.slverr = !hitAny;
      end
      if (accessPh && pwrite && hitAny) begin
         if (regIdx == phy_an_energy_detect_powerdown_pkg::IDX_TIMING) begin
            s_nxt.timing = pwdata[15:0] & phy_an_energy_detect_powerdown_pkg::TIMING_MASK;
         end
         if (regIdx == phy_an_energy_detect_powerdown_pkg::IDX_MODECTL) begin
            s_nxt.edpdEn = pwdata[phy_an_energy_detect_powerdown_pkg::M_EDPDEN];
         end
      end

      // Latched bits: only bits shown by this read are cleared, and a new event wins
      if (rdExpDone) begin
         s_nxt.pdFault = s_r.pdFault & ~s_r.rdata[phy_an_energy_detect_powerdown_pkg::X_PDFAULT];
         s_nxt.pageRx  = s_r.pageRx & ~s_r.rdata[phy_an_energy_detect_powerdown_pkg::X_PAGERX];
      end
      if (pdFaultEvt) begin
         s_nxt.pdFault = 1'b1;
      end

      // Partner code words
      if (anRestart) begin
         s_nxt.ack    = 1'b0;
         s_nxt.anAble = 1'b0;
      end
      if (codeWord.valid) begin
         s_nxt.partner = codeWord.word & phy_an_energy_detect_powerdown_pkg::PARTNER_MASK;
         s_nxt.ack     = 1'b1;
         s_nxt.anAble  = 1'b1;
         s_nxt.pageRx  = 1'b1;
      end

      // Millisecond tick shared by every timer
      if (s_r.msCnt >= MS_CYCLES - 1) begin
         s_nxt.msCnt  = 32'h0000_0000;
         s_nxt.msTick = 1'b1;
      end else begin
         s_nxt.msCnt  = s_r.msCnt + 32'h0000_0001;
         s_nxt.msTick = 1'b0;
      end

      // Power-down state machine
      unique case (s_r.st)
         phy_an_energy_detect_powerdown_pkg::ST_AWAKE: begin
            s_nxt.txMs    = 12'h000;
            s_nxt.rxMs    = 12'h000;
            s_nxt.rxFirst = 1'b0;
            if (s_r.edpdEn && !energyPresent) begin
               s_nxt.st = phy_an_energy_detect_powerdown_pkg::ST_ENERGY_DETECT_POWERDOWN;
            end
         end
         phy_an_energy_detect_powerdown_pkg::ST_ENERGY_DETECT_POWERDOWN: begin
            if (s_r.timing[phy_an_energy_detect_powerdown_pkg::T_TXEN] && s_r.edpdEn) begin
               if (s_r.msTick) begin
                  if (s_r.txMs >= txLimit - 12'h001) begin
                     s_nxt.txMs    = 12'h000;
                     s_nxt.txPulse = 1'b1;
                  end else begin
                     s_nxt.txMs = s_r.txMs + 12'h001;
                  end
               end
            end else begin
               s_nxt.txMs = 12'h000;
            end
            if (s_r.rxFirst && s_r.msTick) begin
               if (s_r.rxMs >= rxLimit) begin
                  s_nxt.rxFirst = 1'b0;
               end else begin
                  s_nxt.rxMs = s_r.rxMs + 12'h001;
               end
            end
            if (rxLinkPulse) begin
               if (s_r.timing[phy_an_energy_detect_powerdown_pkg::T_RXSINGLE]) begin
                  s_nxt.st = phy_an_energy_detect_powerdown_pkg::ST_WAKE;
               end else if (s_r.rxFirst && s_r.rxMs < rxLimit) begin
                  s_nxt.st = phy_an_energy_detect_powerdown_pkg::ST_WAKE;
               end else begin
                  s_nxt.rxFirst = 1'b1;
                  s_nxt.rxMs    = 12'h000;
               end
            end
            // Losing the enable leaves power-down at once without a wake event
            if (!s_r.edpdEn || energyPresent) begin
               s_nxt.st = phy_an_energy_detect_powerdown_pkg::ST_AWAKE;
            end
         end
         phy_an_energy_detect_powerdown_pkg::ST_WAKE: begin
            s_nxt.wake = 1'b1;
            s_nxt.st   = phy_an_energy_detect_powerdown_pkg::ST_AWAKE;
         end
         default: begin
            s_nxt.st = phy_an_energy_detect_powerdown_pkg::ST_AWAKE;
         end
      endcase

      // Crossover extension in milliseconds
      s_nxt.xoverExt = 13'h0000;
      if (s_r.edpdEn && s_r.timing[phy_an_energy_detect_powerdown_pkg::T_EXTEDPD]) begin
         s_nxt.xoverExt = phy_an_energy_detect_powerdown_pkg::MS_EXT_ENERGY_DETECT_POWERDOWN;
      end
      if (crossoverEnable && forcedManual && s_r.timing[phy_an_energy_detect_powerdown_pkg::T_EXTMAN]) begin
         s_nxt.xoverExt = s_nxt.xoverExt + phy_an_energy_detect_powerdown_pkg::MS_EXT_MANUAL;
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r          <= '0;
         s_r.st       <= phy_an_energy_detect_powerdown_pkg::ST_AWAKE;
         s_r.partner  <= phy_an_energy_detect_powerdown_pkg::PARTNER_RST;
         s_r.timing   <= phy_an_energy_detect_powerdown_pkg::TIMING_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign txLinkPulse   = s_r.txPulse;
   assign wakeEvt       = s_r.wake;
   assign edpdActive    = (s_r.st == phy_an_energy_detect_powerdown_pkg::ST_ENERGY_DETECT_POWERDOWN);
   assign xoverExtendMs = s_r.xoverExt;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_np_reset_zero: assert property (!$past(rst_n) |-> !s_r.partner[15])
      else $error("partner next-page bit not zero after reset");
   chk_ack_on_word: assert property (codeWord.valid |=> s_r.ack && s_r.anAble)
      else $error("acknowledge not set after code word");
   chk_rfault_copy: assert property (codeWord.valid |=> s_r.partner[13] == $past(codeWord.word[13]))
      else $error("remote fault bit does not follow partner");
   chk_pause_copy: assert property (codeWord.valid |=> s_r.partner[11:10] == $past(codeWord.word[11:10]))
      else $error("pause field does not follow partner");
   chk_ability_copy: assert property (codeWord.valid |=> s_r.partner[9:5] == $past(codeWord.word[9:5]))
      else $error("ability bits do not follow partner");
   chk_pdfault_latch: assert property (pdFaultEvt |=> s_r.pdFault ##1 (s_r.pdFault || $past(rdExpDone)))
      else $error("parallel fault not latched");
   chk_pagerx_hold: assert property (s_r.pageRx && !rdExpDone |=> s_r.pageRx)
      else $error("page received dropped without read");
   chk_local_np_zero: assert property (setupPh && regIdx == 6'h06 |=> !prdata[2])
      else $error("local next-page bit read as one");
   chk_tx_only_energy_detect_powerdown: assert property (txLinkPulse |-> $past(edpdActive && s_r.timing[15], 1))
      else $error("link pulse sent outside power-down");
   chk_single_wake: assert property (edpdActive && s_r.timing[12] && rxLinkPulse && s_r.edpdEn && !energyPresent
                                     |=> ##1 wakeEvt)
      else $error("single pulse did not wake");
   chk_xover_ext: assert property (s_r.edpdEn && s_r.timing[1] && !(crossoverEnable && forcedManual && s_r.timing[0])
                                   |=> xoverExtendMs == phy_an_energy_detect_powerdown_pkg::MS_EXT_ENERGY_DETECT_POWERDOWN)
      else $error("power-down crossover extension wrong");

   cov_word_rx: cover property (codeWord.valid ##1 rdExpDone);
   cov_tx_pulse: cover property (txLinkPulse);
   cov_wake: cover property (wakeEvt);

endmodule // phy_an_energy_detect_powerdown_regs
`default_nettype wire

/* File: test/link_partner_model.sv */
// Remote link partner model: sends code words and single link pulses on request
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
   input  wire logic                       clk,
   input  wire logic                       sendWord,
   input  wire logic [15:0]                wordIn,
   input  wire logic                       sendPulse,
   output var  phy_an_energy_detect_powerdown_pkg::code_word_t codeWord,
   output var  logic                       rxLinkPulse
);
   // Idle word lines flip every cycle so a stale word is never taken as valid data
   initial begin
      codeWord = '0;
      rxLinkPulse = 1'b0;
      forever begin
         @(posedge clk);
         codeWord.valid <= sendWord;
         codeWord.word  <= sendWord ? wordIn : ~codeWord.word;
         rxLinkPulse    <= sendPulse;
      end
   end
endmodule // link_partner_model
`default_nettype wire

/* File: test/phy_an_energy_detect_powerdown_regs_test.sv */
// Self-checking bench for the partner, expansion and power-down timing registers
`timescale 1ns/1ps
`default_nettype none
module phy_an_energy_detect_powerdown_regs_test;
   localparam int MS = 4;
   localparam logic [7:0] A_PART = {phy_an_energy_detect_powerdown_pkg::IDX_PARTNER, 2'b00};
   localparam logic [7:0] A_EXP  = {phy_an_energy_detect_powerdown_pkg::IDX_EXPANSION, 2'b00};
   localparam logic [7:0] A_TIM  = {phy_an_energy_detect_powerdown_pkg::IDX_TIMING, 2'b00};
   localparam logic [7:0] A_MODE = {phy_an_energy_detect_powerdown_pkg::IDX_MODECTL, 2'b00};
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        sendWord, sendPulse, anRestart, pdFaultEvt, energyPresent;
   logic        crossoverEnable, forcedManual, txLinkPulse, edpdActive, wakeEvt, rxLinkPulse;
   logic [15:0] wordIn;
   logic [12:0] xoverExtendMs;
   phy_an_energy_detect_powerdown_pkg::code_word_t codeWord;
   int          err_total, tests_run, t0, t1, d;
   int          n = 0;
   logic [31:0] q;
   logic        e;
   logic [15:0] w;
   int          txMs[4] = '{phy_an_energy_detect_powerdown_pkg::MS_TX_1S, phy_an_energy_detect_powerdown_pkg::MS_TX_768,
                            phy_an_energy_detect_powerdown_pkg::MS_TX_512, phy_an_energy_detect_powerdown_pkg::MS_TX_256};
   logic [15:0] words[4] = '{16'h0021, 16'hA5A1, 16'h3B41, 16'hAFE1};

   phy_an_energy_detect_powerdown_regs #(.MS_CYCLES(MS)) u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .codeWord(codeWord), .anRestart(anRestart), .pdFaultEvt(pdFaultEvt), .rxLinkPulse(rxLinkPulse),
      .energyPresent(energyPresent), .crossoverEnable(crossoverEnable), .forcedManual(forcedManual),
      .txLinkPulse(txLinkPulse), .edpdActive(edpdActive), .wakeEvt(wakeEvt), .xoverExtendMs(xoverExtendMs));
   link_partner_model u_partner (.clk(clk), .sendWord(sendWord), .wordIn(wordIn), .sendPulse(sendPulse),
      .codeWord(codeWord), .rxLinkPulse(rxLinkPulse));

   // ************************************************************
   // Tasks
   // ************************************************************
   initial clk = 1'b0;
   always #4 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // One edge passes before setup so the release of the last transfer never collides with it
   task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'hFFFF, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 16'h0000);
      check(q, exp);
   endtask
   task automatic pulse(input logic [2:0] sel);
      @(posedge clk);
      {pdFaultEvt, anRestart, sendWord} <= sel;
      @(posedge clk);
      {pdFaultEvt, anRestart, sendWord} <= 3'h0;
      repeat (3) @(posedge clk);
   endtask
   task automatic enterPd();
      apb(1'b1, A_MODE, 16'h0000);
      apb(1'b1, A_MODE, 16'h2000);
      repeat (3) @(negedge clk);
      check({31'h0, edpdActive}, 32'h1);
   endtask
   // The wake pulse lasts one cycle, so the window opens right after the pulse is sent
   task automatic pulseWake(input int gap, input logic [31:0] exp);
      int k;
      k = 0;
      d = 0;
      repeat (gap) @(posedge clk);
      @(posedge clk);
      sendPulse <= 1'b1;
      @(posedge clk);
      sendPulse <= 1'b0;
      repeat (6) begin
         @(negedge clk);
         if (wakeEvt === 1'b1) k++;
         if (edpdActive !== 1'b1) d++;
      end
      check(32'(k), exp);
   endtask
   task automatic waitTx(output int at);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (txLinkPulse !== 1'b1 && k < 5000);
      at = n;
   endtask
   always @(posedge clk) n <= n + 1;

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, sendWord, sendPulse, anRestart} = '0;
      {pdFaultEvt, energyPresent, crossoverEnable, forcedManual, wordIn, err_total, tests_run, d} = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(A_PART, 32'h0);
      rd(A_EXP, 32'h0);
      rd(A_TIM, 32'h0);
      apb(1'b0, 8'h20, 16'h0000);
      check({31'h0, e}, 32'h1);
      check(q, 32'h0);
      apb(1'b1, A_TIM, 16'hFFFF);
      rd(A_TIM, {16'h0, phy_an_energy_detect_powerdown_pkg::TIMING_MASK});
      for (int p = 0; p < 4; p++) begin
         w = words[p];
         @(posedge clk);
         wordIn <= w;
         pulse(3'h1);
         rd(A_PART, {16'h0, (w & phy_an_energy_detect_powerdown_pkg::PARTNER_MASK) | 16'h4000});
         rd(A_EXP, {28'h0, w[15], 3'b011});
         rd(A_EXP, {28'h0, w[15], 3'b001});
      end
      pulse(3'h2);
      rd(A_PART, {16'h0, w & phy_an_energy_detect_powerdown_pkg::PARTNER_MASK});
      rd(A_EXP, 32'h8);
      pulse(3'h4);
      rd(A_EXP, 32'h18);
      rd(A_EXP, 32'h8);
      apb(1'b1, A_MODE, 16'h0000);
      apb(1'b1, A_TIM, 16'h8000);
      waitTx(t0);
      check({31'h0, edpdActive}, 32'h0);
      check({31'h0, txLinkPulse}, 32'h0);
      enterPd();
      rd(A_MODE, 32'h2000);
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, A_TIM, {1'b1, 2'(s), 13'h0000});
         waitTx(t0);
         waitTx(t1);
         check(32'(t1 - t0), 32'(txMs[s] * MS));
      end
      apb(1'b1, A_TIM, 16'h6000);
      t0 = n;
      waitTx(t1);
      check(32'(t1 - t0), 32'(5000));
      pulseWake(0, 0);
      pulseWake(100, 1);
      enterPd();
      pulseWake(0, 0);
      pulseWake(300, 0);
      pulseWake(100, 1);
      apb(1'b1, A_TIM, 16'h0400);
      enterPd();
      pulseWake(0, 0);
      pulseWake(600, 1);
      apb(1'b1, A_TIM, 16'h1000);
      enterPd();
      pulseWake(0, 1);
      // Out of power-down for the wake and awake cycles, then back in while the line stays quiet
      check(32'(d), 32'h2);
      apb(1'b1, A_TIM, 16'h0003);
      crossoverEnable <= 1'b1;
      forcedManual <= 1'b1;
      enterPd();
      check(32'(xoverExtendMs), 32'(phy_an_energy_detect_powerdown_pkg::MS_EXT_ENERGY_DETECT_POWERDOWN + phy_an_energy_detect_powerdown_pkg::MS_EXT_MANUAL));
      @(posedge clk);
      energyPresent <= 1'b1;
      repeat (3) @(negedge clk);
      check({31'h0, edpdActive}, 32'h0);
      apb(1'b1, A_MODE, 16'h0000);
      repeat (3) @(negedge clk);
      check(32'(xoverExtendMs), 32'(phy_an_energy_detect_powerdown_pkg::MS_EXT_MANUAL));
      @(posedge clk);
      forcedManual <= 1'b0;
      repeat (3) @(negedge clk);
      check(32'(xoverExtendMs), 32'h0);
      stop_test();
   end
   initial begin
      #(640000);
      err_total++;
      stop_test();
   end
endmodule // phy_an_energy_detect_powerdown_regs_test
`default_nettype wire
